// >>> verilog/snc_params.svh
// Constants for the serial clock and memory core.
`ifndef SNC_PARAMS_SVH
`define SNC_PARAMS_SVH
// ==========================================================
// Address space
`define SNC_MEM_BYTES 64
`define SNC_CLK_REGS 20
`define SNC_CAL_REGS 8
`define SNC_PTR_RST 6'h00
// ==========================================================
// Serial port
`define SNC_DEV_ADDR 8'hD0
`define SNC_BUS_MAX_KHZ 400
// ==========================================================
// Time base
`define SNC_OSC_HZ 32768
`define SNC_TICKS_PER_SEC 100
`define SNC_ACC_W 16
// ==========================================================
// Reset values and debounce
`define SNC_TIME_RST 64'h00_01_01_01_00_00_00_00
`define SNC_DEB_CYCLES 16
`endif

// >>> verilog/snc_pkg.sv
// Types shared by the serial clock and memory core.
package snc_pkg;
  // ==========================================================
  // Calendar image, hundredths in the low byte.
  typedef struct packed {
    logic [7:0] year;
    logic [7:0] month;
    logic [7:0] date;
    logic [7:0] day;
    logic [7:0] hour;
    logic [7:0] min;
    logic [7:0] sec;
    logic [7:0] hund;
  } snc_time_t;
  // ==========================================================
  // Byte load into the live calendar.
  typedef struct packed {
    logic en;
    logic [2:0] addr;
    logic [7:0] data;
  } snc_load_t;
  // ==========================================================
  // Serial slave states.
  typedef enum logic [8:0] {
    SLV_IDLE = 9'h001,
    SLV_ADDR = 9'h002,
    SLV_AACK = 9'h004,
    SLV_WA = 9'h008,
    SLV_WACK = 9'h010,
    SLV_WD = 9'h020,
    SLV_DACK = 9'h040,
    SLV_RD = 9'h080,
    SLV_RACK = 9'h100
  } snc_slv_t;
endpackage

// >>> verilog/snc_calendar.sv
// Live BCD clock and calendar counters.
`timescale 1ns/1ps
`include "snc_params.svh"
module snc_calendar
  import snc_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_tick,
  input wire snc_load_t i_load,
  output snc_time_t o_time
);
  snc_time_t t_q;
  snc_time_t t_d;

  // ==========================================================
  // Helpers
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
  endfunction

  function automatic logic leap(input logic [7:0] y);
    leap = (!y[4] && (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8)) ||
           (y[4] && (y[3:0] == 4'h2 || y[3:0] == 4'h6));
  endfunction

  function automatic logic [7:0] month_days(input logic [7:0] m, input logic [7:0] y);
    case (m)
      8'h02: month_days = leap(y) ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: month_days = 8'h30;
      default: month_days = 8'h31;
    endcase
  endfunction

  // ==========================================================
  // Counting
  always_comb begin
    logic c;
    logic [63:0] v;
    logic [7:0] h;
    c = i_tick;
    v = 64'h0;
    h = 8'h00;
    t_d = t_q;
    if (c) begin
      if (t_q.hund == 8'h99) t_d.hund = 8'h00;
      else begin
        t_d.hund = bcd_inc(t_q.hund);
        c = 1'b0;
      end
    end
    if (c) begin
      if (t_q.sec[6:0] == 7'h59) t_d.sec = 8'h00;
      else begin
        t_d.sec = bcd_inc(t_q.sec);
        c = 1'b0;
      end
    end
    if (c) begin
      if (t_q.min[6:0] == 7'h59) t_d.min = 8'h00;
      else begin
        t_d.min = bcd_inc(t_q.min);
        c = 1'b0;
      end
    end
    if (c) begin
      if (t_q.hour[5:0] == 6'h23) t_d.hour[5:0] = 6'h00;
      else begin
        h = bcd_inc({2'b00, t_q.hour[5:0]});
        t_d.hour[5:0] = h[5:0];
        c = 1'b0;
      end
    end
    if (c) begin
      t_d.day = (t_q.day == 8'h07) ? 8'h01 : bcd_inc(t_q.day);
      if (t_q.date == month_days(t_q.month, t_q.year)) t_d.date = 8'h01;
      else begin
        t_d.date = bcd_inc(t_q.date);
        c = 1'b0;
      end
    end
    if (c) begin
      if (t_q.month == 8'h12) t_d.month = 8'h01;
      else begin
        t_d.month = bcd_inc(t_q.month);
        c = 1'b0;
      end
    end
    if (c) begin
      if (t_q.year == 8'h99) begin
        t_d.year = 8'h00;
        t_d.hour[7:6] = t_q.hour[7:6] + 2'b01;
      end else t_d.year = bcd_inc(t_q.year);
    end
    if (i_load.en) begin
      v = t_d;
      v[{3'b000, i_load.addr} * 6'h08 +: 8] = i_load.data;
      t_d = v;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) t_q <= `SNC_TIME_RST;
    else t_q <= t_d;
  end

  assign o_time = t_q;
endmodule

// >>> verilog/snc_core.sv
// Serial real-time clock core with memory, slave port and supervisor.
`timescale 1ns/1ps
`include "snc_params.svh"
// Summary of operation
// - 64 bytes: 8 clock registers, 56 RAM.
// - Time registers hold two BCD digits.
// - Time base from 32.768 kHz oscillator.
// - Eight calendar bytes; bytes 08h-3Fh are RAM.
// - Pointer advances after every data byte.
// - Century to hundredths, 24-hour hour field.
// - Month lengths and leap years to 2100.
// - Power fail gates external SRAM enable.
// - Two debounced inputs drive reset output.
// - Two-wire serial link up to 400 kHz.
// - Answer only slave address D0h.
// - Pointer advances on acknowledge clock only.
// - Freeze visible time during a transfer with pointer 00h-07h.
// - Power fail aborts access, clears pointer.
module snc_core
  import snc_pkg::*;
#(
  parameter int DEB_CYCLES = `SNC_DEB_CYCLES
) (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  input wire logic i_osc_32k,
  input wire logic i_pwr_fail,
  input wire logic i_vcc_below_vso,
  input wire logic i_ext_reset_in_a_n,
  input wire logic i_ext_reset_in_b_n,
  input wire logic i_backed_ext_sram_ce_n,
  output logic o_backed_ext_sram_ce_n,
  output logic o_batt_sel,
  output logic o_reset_n
);
  localparam logic [`SNC_ACC_W-1:0] ACC_STEP = `SNC_ACC_W'(`SNC_TICKS_PER_SEC);
  localparam logic [`SNC_ACC_W-1:0] ACC_WRAP = `SNC_ACC_W'(`SNC_OSC_HZ);

  snc_slv_t slv_q, slv_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d;
  logic [5:0] ptr_q, ptr_d;
  logic oe_q, oe_d;
  logic rw_q, rw_d;
  logic nack_q, nack_d;
  logic scl_q, sda_q;
  logic scl_rise, scl_fall, start, stop;
  logic wr_en;
  logic [7:0] rdata;
  logic [7:0] mem_q [0:`SNC_MEM_BYTES-1];
  snc_time_t live, snap_q, snap_d;
  snc_load_t load;
  logic osc_q, tick_q, tick_d;
  logic [`SNC_ACC_W-1:0] acc_q, acc_d;
  logic [1:0] deb_q;
  logic rst_n_d, ce_n_d;

  // ==========================================================
  // Line events
  assign scl_rise = i_scl & ~scl_q;
  assign scl_fall = ~i_scl & scl_q;
  assign start = scl_q & i_scl & sda_q & ~i_sda;
  assign stop = scl_q & i_scl & ~sda_q & i_sda;

  // ==========================================================
  // Read path
  always_comb begin
    logic [63:0] v;
    v = snap_q;
    if (ptr_q < 6'(`SNC_CAL_REGS)) rdata = v[{3'b000, ptr_q[2:0]} * 6'h08 +: 8];
    else rdata = mem_q[ptr_q];
  end

  // ==========================================================
  // Serial slave
  always_comb begin
    slv_d = slv_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    ptr_d = ptr_q;
    oe_d = oe_q;
    rw_d = rw_q;
    nack_d = nack_q;
    wr_en = 1'b0;
    if (i_pwr_fail) begin
      slv_d = SLV_IDLE;
      ptr_d = `SNC_PTR_RST;
      oe_d = 1'b0;
      cnt_d = 4'h0;
    end else if (start) begin
      slv_d = SLV_ADDR;
      cnt_d = 4'h0;
      oe_d = 1'b0;
    end else if (stop) begin
      slv_d = SLV_IDLE;
      oe_d = 1'b0;
    end else begin
      case (slv_q)
        SLV_ADDR, SLV_WA, SLV_WD: begin
          if (scl_rise) begin
            sh_d = {sh_q[6:0], i_sda};
            cnt_d = cnt_q + 4'h1;
          end
          if (scl_fall && cnt_q == 4'h8) begin
            cnt_d = 4'h0;
            oe_d = 1'b1;
            if (slv_q == SLV_ADDR) begin
              if (sh_q[7:1] == 7'(`SNC_DEV_ADDR >> 1)) begin
                rw_d = sh_q[0];
                slv_d = SLV_AACK;
              end else begin
                oe_d = 1'b0;
                slv_d = SLV_IDLE;
              end
            end else if (slv_q == SLV_WA) begin
              ptr_d = sh_q[5:0];
              slv_d = SLV_WACK;
            end else begin
              wr_en = 1'b1;
              slv_d = SLV_DACK;
            end
          end
        end
        SLV_AACK: begin
          if (scl_fall) begin
            cnt_d = 4'h0;
            if (rw_q) begin
              sh_d = rdata;
              oe_d = ~rdata[7];
              slv_d = SLV_RD;
            end else begin
              oe_d = 1'b0;
              slv_d = SLV_WA;
            end
          end
        end
        SLV_WACK: begin
          if (scl_fall) begin
            oe_d = 1'b0;
            slv_d = SLV_WD;
          end
        end
        SLV_DACK: begin
          if (scl_fall) begin
            oe_d = 1'b0;
            ptr_d = ptr_q + 6'h01;
            slv_d = SLV_WD;
          end
        end
        SLV_RD: begin
          if (scl_fall) begin
            cnt_d = cnt_q + 4'h1;
            if (cnt_q == 4'h7) begin
              oe_d = 1'b0;
              slv_d = SLV_RACK;
            end else begin
              sh_d = {sh_q[6:0], 1'b0};
              oe_d = ~sh_q[6];
            end
          end
        end
        SLV_RACK: begin
          if (scl_rise) begin
            nack_d = i_sda;
            ptr_d = ptr_q + 6'h01;
          end
          if (scl_fall) begin
            cnt_d = 4'h0;
            if (nack_q) slv_d = SLV_IDLE;
            else begin
              sh_d = rdata;
              oe_d = ~rdata[7];
              slv_d = SLV_RD;
            end
          end
        end
        default: slv_d = SLV_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      slv_q <= SLV_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      ptr_q <= `SNC_PTR_RST;
      oe_q <= 1'b0;
      rw_q <= 1'b0;
      nack_q <= 1'b0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      slv_q <= slv_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      ptr_q <= ptr_d;
      oe_q <= oe_d;
      rw_q <= rw_d;
      nack_q <= nack_d;
      scl_q <= i_scl;
      sda_q <= i_sda;
    end
  end

  // ==========================================================
  // Register and RAM store
  always_ff @(posedge i_ref_clk) begin
    if (wr_en && ptr_q >= 6'(`SNC_CAL_REGS)) mem_q[ptr_q] <= sh_q;
  end

  assign load = '{en: wr_en && ptr_q < 6'(`SNC_CAL_REGS), addr: ptr_q[2:0], data: sh_q};

  // ==========================================================
  // Visible time snapshot
  always_comb begin
    logic [63:0] v;
    v = snap_q;
    // hold during a transfer with pointer in clock bytes
    if (!(slv_q != SLV_IDLE && ptr_q < 6'(`SNC_CAL_REGS))) v = live;
    if (load.en) v[{3'b000, load.addr} * 6'h08 +: 8] = load.data;
    snap_d = v;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) snap_q <= `SNC_TIME_RST;
    else snap_q <= snap_d;
  end

  // ==========================================================
  // Time base
  always_comb begin
    acc_d = acc_q;
    tick_d = 1'b0;
    if (i_osc_32k && !osc_q) begin
      acc_d = acc_q + ACC_STEP;
      if (acc_d >= ACC_WRAP) begin
        acc_d = acc_d - ACC_WRAP;
        tick_d = 1'b1;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      acc_q <= '0;
      tick_q <= 1'b0;
      osc_q <= 1'b0;
    end else begin
      acc_q <= acc_d;
      tick_q <= tick_d;
      osc_q <= i_osc_32k;
    end
  end

  snc_calendar u_cal (
    .i_ref_clk(i_ref_clk),
    .i_srst(i_srst),
    .i_tick(tick_q),
    .i_load(load),
    .o_time(live)
  );

  // ==========================================================
  // Reset input debounce
  for (genvar g = 0; g < 2; g++) begin : g_deb
    logic [15:0] dc_q, dc_d;
    logic dv_d;
    logic raw;
    assign raw = (g == 0) ? i_ext_reset_in_a_n : i_ext_reset_in_b_n;
    always_comb begin
      dc_d = 16'h0000;
      dv_d = deb_q[g];
      if (raw != deb_q[g]) begin
        dc_d = dc_q + 16'h0001;
        if (dc_q == 16'(DEB_CYCLES - 1)) begin
          dv_d = raw;
          dc_d = 16'h0000;
        end
      end
    end
    always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
        dc_q <= 16'h0000;
        deb_q[g] <= 1'b1;
      end else begin
        dc_q <= dc_d;
        deb_q[g] <= dv_d;
      end
    end
  end

  // ==========================================================
  // Supervisor outputs
  always_comb begin
    // either input or power fail resets
    rst_n_d = ~i_pwr_fail & deb_q[0] & deb_q[1];
    // gate external SRAM on power fail
    ce_n_d = i_backed_ext_sram_ce_n | i_pwr_fail;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_reset_n <= 1'b0;
      o_backed_ext_sram_ce_n <= 1'b1;
      o_batt_sel <= 1'b0;
      o_sda_oe <= 1'b0;
      o_sda_out <= 1'b0;
    end else begin
      o_reset_n <= rst_n_d;
      o_backed_ext_sram_ce_n <= ce_n_d;
      o_batt_sel <= i_vcc_below_vso;
      o_sda_oe <= oe_d;
      o_sda_out <= 1'b0;
    end
  end
endmodule

// >>> dv/snc_core_assertions.sv
// Port checks for the serial clock core.
`timescale 1ns/1ps
module snc_core_assertions #(
  parameter int DEB_CYCLES = 16
) (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_scl,
  input wire logic i_pwr_fail,
  input wire logic i_vcc_below_vso,
  input wire logic i_ext_reset_in_a_n,
  input wire logic i_ext_reset_in_b_n,
  input wire logic i_backed_ext_sram_ce_n,
  input wire logic o_sda_out,
  input wire logic o_sda_oe,
  input wire logic o_backed_ext_sram_ce_n,
  input wire logic o_batt_sel,
  input wire logic o_reset_n
);
  // ====================
  // Cycles with an external reset input held low.
  logic [7:0] low_q;
  logic [7:0] low_d;
  always_comb begin
    low_d = low_q;
    if (i_ext_reset_in_a_n && i_ext_reset_in_b_n) begin
      low_d = 8'h00;
    end else if (low_q != 8'hFF) begin
      low_d = low_q + 8'h01;
    end
  end
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      low_q <= 8'h00;
    end else begin
      low_q <= low_d;
    end
  end
  // ====================
  // Assertions.
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_srst);
  a_ce_gated: assert property (
    !i_srst |=> o_backed_ext_sram_ce_n == $past(i_backed_ext_sram_ce_n | i_pwr_fail))
    else $error("external enable not gated");
  a_batt_follow: assert property (
    !i_srst |=> o_batt_sel == $past(i_vcc_below_vso))
    else $error("battery select wrong");
  a_fail_reset: assert property (
    i_pwr_fail |=> !o_reset_n)
    else $error("reset not driven on power fail");
  a_srst_reset: assert property (
    disable iff (1'b0) i_srst |=> !o_reset_n)
    else $error("reset not driven on power-on reset");
  a_ext_reset: assert property (
    int'(low_q) > DEB_CYCLES + 3 |-> !o_reset_n)
    else $error("external reset input ignored");
  a_open_drain: assert property (
    o_sda_oe |-> !o_sda_out)
    else $error("data line driven high");
  a_fail_quiet: assert property (
    i_pwr_fail [*3] |-> !o_sda_oe)
    else $error("data line driven during power fail");
  a_sda_scl_low: assert property (
    $changed(o_sda_oe) |-> !i_scl || $past(i_pwr_fail) || $past(i_pwr_fail, 2))
    else $error("data changed while clock high");
endmodule
bind snc_core snc_core_assertions #(.DEB_CYCLES(DEB_CYCLES)) snc_core_assertions_inst (
  .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_scl(i_scl), .i_pwr_fail(i_pwr_fail),
  .i_vcc_below_vso(i_vcc_below_vso), .i_ext_reset_in_a_n(i_ext_reset_in_a_n),
  .i_ext_reset_in_b_n(i_ext_reset_in_b_n), .i_backed_ext_sram_ce_n(i_backed_ext_sram_ce_n),
  .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .o_backed_ext_sram_ce_n(o_backed_ext_sram_ce_n),
  .o_batt_sel(o_batt_sel), .o_reset_n(o_reset_n)
);

// >>> dv/snc_i2c_master.sv
// Two-wire bus master model for the serial clock core.
`timescale 1ns/1ps
module snc_i2c_master #(
  parameter int HALF = 5
) (
  input wire logic i_ref_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda
);
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  task automatic hold();
    repeat (HALF) @(posedge i_ref_clk);
    #1;
  endtask
  task automatic start();
    o_sda = 1'b1;
    hold();
    o_scl = 1'b1;
    hold();
    o_sda = 1'b0;
    hold();
    o_scl = 1'b0;
    hold();
  endtask
  task automatic stop();
    o_sda = 1'b0;
    hold();
    o_scl = 1'b1;
    hold();
    o_sda = 1'b1;
    hold();
  endtask
  // one bit, data steady while the clock is high
  task automatic bit_x(input logic b, output logic r);
    o_sda = b;
    hold();
    o_scl = 1'b1;
    hold();
    r = i_sda;
    o_scl = 1'b0;
  endtask
  task automatic wr(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r);
    end
    bit_x(1'b1, ack);
  endtask
  task automatic rd(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, d[i]);
    end
    bit_x(nack, r);
  endtask
endmodule

// >>> dv/test_serial_rtc_nvram_supervisor_core.sv
// Self-checking bench for the serial clock core.
`timescale 1ns/1ps
`include "snc_params.svh"
module test_serial_rtc_nvram_supervisor_core;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic osc = 1'b0;
  logic pf = 1'b0;
  logic vso = 1'b0;
  logic ra_n = 1'b1;
  logic rb_n = 1'b1;
  logic ce_n = 1'b1;
  logic scl, m_sda, sda, sda_out, sda_oe, ce_out_n, batt, reset_n;
  int mismatches = 0;
  int checks_done = 0;
  int rises = 0;
  logic [7:0] rd_q[$];
  logic [7:0] none_q[$];
  assign sda = m_sda & (sda_oe ? sda_out : 1'b1);
  snc_core #(.DEB_CYCLES(2)) snc_core_inst (
    .i_ref_clk(clk), .i_srst(srst), .i_scl(scl), .i_sda(sda), .o_sda_out(sda_out),
    .o_sda_oe(sda_oe), .i_osc_32k(osc), .i_pwr_fail(pf), .i_vcc_below_vso(vso),
    .i_ext_reset_in_a_n(ra_n), .i_ext_reset_in_b_n(rb_n), .i_backed_ext_sram_ce_n(ce_n),
    .o_backed_ext_sram_ce_n(ce_out_n), .o_batt_sel(batt), .o_reset_n(reset_n)
  );
  snc_i2c_master bus (.i_ref_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda(m_sda));
  initial begin
    forever #12.5 clk = ~clk;
  end
  // ====================
  // Shared tasks.
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr_seq(input logic [5:0] a, input logic [7:0] d[$]);
    logic ack;
    bus.start();
    bus.wr(`SNC_DEV_ADDR, ack);
    chk("ack", 8'h00, {7'h00, ack});
    bus.wr({2'b00, a}, ack);
    chk("ack", 8'h00, {7'h00, ack});
    foreach (d[i]) begin
      bus.wr(d[i], ack);
      chk("ack", 8'h00, {7'h00, ack});
    end
    bus.stop();
  endtask
  task automatic rd_seq(input int n);
    logic ack;
    logic [7:0] b;
    rd_q.delete();
    bus.start();
    bus.wr(`SNC_DEV_ADDR | 8'h01, ack);
    chk("ack", 8'h00, {7'h00, ack});
    for (int i = 0; i < n; i++) begin
      bus.rd(i == n - 1, b);
      rd_q.push_back(b);
    end
    bus.stop();
  endtask
  task automatic tick_once();
    int goal;
    goal = rises * `SNC_TICKS_PER_SEC / `SNC_OSC_HZ + 1;
    while (rises * `SNC_TICKS_PER_SEC / `SNC_OSC_HZ < goal) begin
      osc = 1'b1;
      cyc(2);
      osc = 1'b0;
      cyc(2);
      rises++;
    end
  endtask
  // ====================
  // Scenarios.
  task automatic test_ram();
    wr_seq(6'h3E, '{8'h11, 8'h22, 8'h33});
    wr_seq(6'h3E, none_q);
    rd_seq(3);
    chk("ram 3E", 8'h11, rd_q[0]);
    chk("ram 3F", 8'h22, rd_q[1]);
    chk("hundredths", 8'h33, rd_q[2]);
    rd_seq(1);
    chk("seconds", 8'h00, rd_q[0]);
    $display("test ram done");
  endtask
  task automatic test_bad_addr();
    logic [7:0] bad[3] = '{8'hA0, 8'hD2, 8'h50};
    logic ack;
    foreach (bad[i]) begin
      bus.start();
      bus.wr(bad[i], ack);
      chk("nack", 8'h01, {7'h00, ack});
      bus.stop();
    end
    $display("test address done");
  endtask
  task automatic test_calendar();
    logic [63:0] sv[4] = '{64'h01_02_28_07_23_59_59_99, 64'h04_02_28_03_23_59_59_99,
                           64'h05_04_30_02_23_59_59_99, 64'h99_12_31_05_23_59_59_99};
    logic [63:0] ev[4] = '{64'h01_03_01_01_00_00_00_00, 64'h04_02_29_04_00_00_00_00,
                           64'h05_05_01_03_00_00_00_00, 64'h00_01_01_06_40_00_00_00};
    logic [7:0] q[$];
    for (int c = 0; c < 4; c++) begin
      q.delete();
      for (int k = 0; k < 8; k++) begin
        q.push_back(sv[c][8*k +: 8]);
      end
      wr_seq(6'h00, q);
      tick_once();
      wr_seq(6'h00, none_q);
      rd_seq(8);
      for (int k = 0; k < 8; k++) begin
        chk("calendar", ev[c][8*k +: 8], rd_q[k]);
      end
    end
    $display("test calendar done");
  endtask
  task automatic test_freeze();
    logic ack;
    logic [7:0] b;
    wr_seq(6'h00, '{8'h99, 8'h59, 8'h07});
    wr_seq(6'h00, none_q);
    bus.start();
    bus.wr(`SNC_DEV_ADDR | 8'h01, ack);
    chk("ack", 8'h00, {7'h00, ack});
    bus.rd(1'b0, b);
    chk("frozen hundredths", 8'h99, b);
    tick_once();
    bus.rd(1'b0, b);
    chk("frozen seconds", 8'h59, b);
    bus.rd(1'b1, b);
    chk("frozen minutes", 8'h07, b);
    bus.stop();
    wr_seq(6'h00, none_q);
    rd_seq(3);
    chk("hundredths", 8'h00, rd_q[0]);
    chk("seconds", 8'h00, rd_q[1]);
    chk("minutes", 8'h08, rd_q[2]);
    $display("test freeze done");
  endtask
  task automatic test_pf_abort();
    logic r;
    wr_seq(6'h2A, '{8'h5C});
    bus.start();
    bus.wr(`SNC_DEV_ADDR, r);
    bus.wr(8'h2A, r);
    repeat (4) bus.bit_x(1'b1, r);
    pf = 1'b1;
    cyc(10);
    pf = 1'b0;
    cyc(4);
    bus.stop();
    rd_seq(1);
    chk("pointer after fail", 8'h00, rd_q[0]);
    $display("test power fail done");
  endtask
  task automatic test_supervisor();
    pf = 1'b1;
    vso = 1'b1;
    ce_n = 1'b0;
    cyc(3);
    chk("ce out", 8'h01, {7'h00, ce_out_n});
    chk("batt", 8'h01, {7'h00, batt});
    chk("reset out", 8'h00, {7'h00, reset_n});
    pf = 1'b0;
    vso = 1'b0;
    cyc(3);
    chk("ce out", 8'h00, {7'h00, ce_out_n});
    chk("batt", 8'h00, {7'h00, batt});
    ce_n = 1'b1;
    for (int i = 0; i < 2; i++) begin
      cyc(10);
      chk("reset out", 8'h01, {7'h00, reset_n});
      ra_n = (i != 0);
      rb_n = (i == 0);
      cyc(10);
      chk("reset out", 8'h00, {7'h00, reset_n});
      ra_n = 1'b1;
      rb_n = 1'b1;
    end
    $display("test supervisor done");
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ====================
  // Main sequence and watchdog.
  initial begin
    cyc(2);
    chk("reset out", 8'h00, {7'h00, reset_n});
    srst = 1'b0;
    cyc(3);
    test_ram();
    test_bad_addr();
    test_calendar();
    test_freeze();
    test_pf_abort();
    test_supervisor();
    end_sim();
  end
  initial begin
    #1250000;
    mismatches++;
    end_sim();
  end
endmodule
